// >>> hdl/idu_top.sv
// Integer divide unit: four divide forms with flag and condition updates.
// Function
// - Doubleword signed divide, 64-bit quotient only.
// - Signed forms use two's-complement operands.
// - Signed quotient truncates toward zero.
// - Signed doubleword overflow or zero divisor: error.
// - Doubleword record sets compare bits, copies summary.
// - Unsigned forms treat operands as unsigned.
// - Unsigned error only on zero divisor.
// - Word forms use low halves, upper undefined.
// - Signed word overflow or zero divisor: error.
// - Word record in 64-bit mode: compare undefined.
// - Word record 32-bit mode compares low word.
// - Unsigned word record still compares signed.
module idu_top
    import idu_pkg::*;
(
    // Clocking.
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    // Divide request from the pipeline.
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic [1:0]        req_op,
    input  wire logic [DATA_W-1:0] first_source_reg,
    input  wire logic [DATA_W-1:0] second_source_reg,
    input  wire logic              ovf_enable,
    input  wire logic              record_condition_field,
    input  wire logic              mode_64,
    // Architectural flag state held for the core.
    output logic                   overflow_flag,
    output logic                   summary_overflow,
    output logic [3:0]             condition_field_zero,
    // Result to the register file.
    output logic                   res_valid,
    output logic [DATA_W-1:0]      res_data,
    // Avalon-MM slave.
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // Interrupt.
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Two's-complement magnitude of a signed value, used for both operands.
    function automatic logic [DATA_W-1:0] idu_abs(input logic [DATA_W-1:0] v);
        return v[DATA_W-1] ? (~v + 64'h1) : v;
    endfunction : idu_abs

    // Signed compare of a value with zero giving less, greater, equal.
    function automatic logic [2:0] idu_cmp(input logic [DATA_W-1:0] v);
        logic z;
        z = (v == '0);
        return {v[DATA_W-1], !v[DATA_W-1] && !z, z};
    endfunction : idu_cmp

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    idu_state_type     st_r, st_nxt;            // Controller state.
    idu_op_type        op_r, op_nxt;            // Latched operation.
    logic              oe_r, oe_nxt;            // Latched overflow enable.
    logic              rc_r, rc_nxt;            // Latched record field.
    logic              m64_r, m64_nxt;          // Latched 64-bit mode.
    logic              neg_r, neg_nxt;          // Quotient sign to apply.
    logic              err_r, err_nxt;          // Undefined-result case.
    logic              ov_r, ov_nxt;            // Overflow flag.
    logic              so_r, so_nxt;            // Summary overflow flag.
    logic [3:0]        cf_r, cf_nxt;            // Condition field zero.
    logic              rv_r, rv_nxt;            // Result valid pulse.
    logic [DATA_W-1:0] rd_r, rd_nxt;            // Result data.
    logic [1:0]        ist_r, ist_nxt;          // Interrupt status.
    logic [1:0]        imsk_r, imsk_nxt;        // Interrupt mask.
    logic              rd_ack_r, rd_ack_nxt;    // Read data registered, end the wait.
    logic [DATA_W-1:0] a_ext, b_ext;            // Width-adjusted operands.
    logic              is_signed, is_word;      // Decoded op class.
    logic              start;                   // Accept strobe.
    logic              core_busy;               // Divider running.
    logic [DATA_W-1:0] qmag;                    // Unsigned quotient.
    logic [DATA_W-1:0] quot;                    // Signed-corrected quotient.
    logic              done_evt, err_evt;       // Interrupt events.

    ////////////////////////////////////////////////////////////////////////
    // Operand conditioning and error detection.

    always_comb begin
        is_signed = (idu_op_type'(req_op) == IDU_OP_DIVD)
                 || (idu_op_type'(req_op) == IDU_OP_DIVW);
        is_word = req_op[1];
        if (is_word) begin
            a_ext = is_signed ? {{WORD_W{first_source_reg[WORD_W-1]}},
                                 first_source_reg[WORD_W-1:0]}
                              : {{WORD_W{1'b0}}, first_source_reg[WORD_W-1:0]};
            b_ext = is_signed ? {{WORD_W{second_source_reg[WORD_W-1]}},
                                 second_source_reg[WORD_W-1:0]}
                              : {{WORD_W{1'b0}}, second_source_reg[WORD_W-1:0]};
        end else begin
            a_ext = first_source_reg;
            b_ext = second_source_reg;
        end
    end

    assign start = req_valid && req_ready && clk_en;
    assign req_ready = (st_r == IDU_ST_IDLE);

    idu_core u_core (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .clk_en       (clk_en),
        .start        (start),
        .dividend_mag (is_signed ? idu_abs(a_ext) : a_ext),
        .divisor_mag  (is_signed ? idu_abs(b_ext) : b_ext),
        .busy         (core_busy),
        .quot_mag     (qmag)
    );

    assign quot = neg_r ? (~qmag + 64'h1) : qmag;

    ////////////////////////////////////////////////////////////////////////
    // Controller and architectural flag update.

    always_comb begin
        logic [2:0] cmp;
        cmp = '0;
        st_nxt = st_r;
        op_nxt = op_r;
        oe_nxt = oe_r;
        rc_nxt = rc_r;
        m64_nxt = m64_r;
        neg_nxt = neg_r;
        err_nxt = err_r;
        ov_nxt = ov_r;
        so_nxt = so_r;
        cf_nxt = cf_r;
        rv_nxt = 1'b0;
        rd_nxt = rd_r;
        unique case (st_r)
            IDU_ST_IDLE: begin
                if (req_valid) begin
                    op_nxt = idu_op_type'(req_op);
                    oe_nxt = ovf_enable;
                    rc_nxt = record_condition_field;
                    m64_nxt = mode_64;
                    neg_nxt = is_signed && (a_ext[DATA_W-1] ^ b_ext[DATA_W-1]);
                    err_nxt = (b_ext == '0);
                    if (!is_word && is_signed && a_ext == MOST_NEG_DWORD
                        && b_ext == ALL_ONES) begin
                        err_nxt = 1'b1;
                    end
                    if (is_word && is_signed
                        && first_source_reg[WORD_W-1:0] == MOST_NEG_WORD
                        && second_source_reg[WORD_W-1:0] == ALL_ONES[WORD_W-1:0]) begin
                        err_nxt = 1'b1;
                    end
                    st_nxt = IDU_ST_RUN;
                end
            end
            IDU_ST_RUN: begin
                // The divider starts the cycle this state is entered.
                if (!core_busy && !start) begin
                    st_nxt = IDU_ST_DONE;
                end
            end
            IDU_ST_DONE: begin
                rv_nxt = 1'b1;
                st_nxt = IDU_ST_IDLE;
                if (oe_r) begin
                    ov_nxt = err_r;
                    so_nxt = so_r | err_r;
                end
                if (err_r) begin
                    rd_nxt = UNDEF_FILL;
                    cmp = UNDEF_CMP;
                end else if (!op_r[1]) begin
                    rd_nxt = quot;
                    cmp = idu_cmp(quot);
                end else begin
                    rd_nxt = {UNDEF_FILL[DATA_W-1:WORD_W], quot[WORD_W-1:0]};
                    cmp = idu_cmp({{WORD_W{quot[WORD_W-1]}}, quot[WORD_W-1:0]});
                    if (m64_r) begin
                        cmp = UNDEF_CMP;
                    end
                end
                if (rc_r) begin
                    cf_nxt = {cmp, oe_r ? (so_r | err_r) : so_r};
                end
            end
            default: st_nxt = IDU_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= IDU_ST_IDLE;
            op_r <= IDU_OP_DIVD;
            oe_r <= 1'b0;
            rc_r <= 1'b0;
            m64_r <= 1'b0;
            neg_r <= 1'b0;
            err_r <= 1'b0;
            ov_r <= 1'b0;
            so_r <= 1'b0;
            cf_r <= '0;
            rv_r <= 1'b0;
            rd_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            oe_r <= oe_nxt;
            rc_r <= rc_nxt;
            m64_r <= m64_nxt;
            neg_r <= neg_nxt;
            err_r <= err_nxt;
            ov_r <= ov_nxt;
            so_r <= so_nxt;
            cf_r <= cf_nxt;
            rv_r <= rv_nxt;
            rd_r <= rd_nxt;
        end
    end

    assign overflow_flag = ov_r;
    assign summary_overflow = so_r;
    assign condition_field_zero = cf_r;
    assign res_valid = rv_r;
    assign res_data = rd_r;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt registers on the Avalon slave.

    assign done_evt = (st_r == IDU_ST_DONE) && clk_en;
    assign err_evt = done_evt && err_r;

    // Writes take effect at once. A read waits one cycle so that the
    // registered read data already stand at the edge that ends the wait;
    // this costs one cycle per read but keeps the data path registered.
    assign avs_waitrequest = avs_read && !rd_ack_r;

    always_comb begin
        ist_nxt = ist_r;
        imsk_nxt = imsk_r;
        // The acknowledge toggles off after each finished read, so a held
        // read is answered every second cycle.
        rd_ack_nxt = avs_read && !rd_ack_r;
        if (avs_write && avs_address == OFS_IRQ_STATUS) begin
            ist_nxt = ist_r & ~avs_writedata[1:0];
        end
        if (avs_write && avs_address == OFS_IRQ_MASK) begin
            imsk_nxt = avs_writedata[1:0];
        end
        // Setting after clearing lets a same-cycle event win.
        ist_nxt[IRQ_DONE_BIT] = ist_nxt[IRQ_DONE_BIT] | done_evt;
        ist_nxt[IRQ_ERR_BIT] = ist_nxt[IRQ_ERR_BIT] | err_evt;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ist_r <= IRQ_RESET;
            imsk_r <= IRQ_RESET;
            rd_ack_r <= 1'b0;
            avs_readdata <= '0;
        end else if (clk_en) begin
            ist_r <= ist_nxt;
            imsk_r <= imsk_nxt;
            rd_ack_r <= rd_ack_nxt;
            unique case (avs_address)
                OFS_IRQ_STATUS: avs_readdata <= {30'h0, ist_r};
                OFS_IRQ_MASK:   avs_readdata <= {30'h0, imsk_r};
                OFS_UNIT_STATE: avs_readdata <= {24'h0, 2'h0, st_r, cf_r};
                default:        avs_readdata <= 32'h0;
            endcase
        end
    end

    assign irq = |(ist_r & imsk_r);

endmodule : idu_top

// >>> hdl/idu_pkg.sv
// Package of constants and types shared by the integer divide unit.
package idu_pkg;

    // Operand and result widths.
    localparam int DATA_W = 64;
    localparam int WORD_W = 32;
    // Step count of the serial divider: one quotient bit per cycle.
    localparam int DIV_STEPS = 64;
    localparam logic [6:0] STEP_LAST = 7'h3f;
    // Most negative values that overflow when divided by minus one.
    localparam logic [63:0] MOST_NEG_DWORD = 64'h8000_0000_0000_0000;
    localparam logic [31:0] MOST_NEG_WORD = 32'h8000_0000;
    localparam logic [63:0] ALL_ONES = 64'hffff_ffff_ffff_ffff;
    // Value driven where the result is architecturally undefined.
    localparam logic [63:0] UNDEF_FILL = 64'h0000_0000_0000_0000;
    localparam logic [2:0] UNDEF_CMP = 3'h0;
    // Field positions inside the four-bit condition field zero.
    localparam int CF_LT_POS = 3;
    localparam int CF_GT_POS = 2;
    localparam int CF_EQ_POS = 1;
    localparam int CF_SO_POS = 0;
    // Register offsets of the interrupt block on the Avalon slave.
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h0;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h4;
    localparam logic [3:0] OFS_UNIT_STATE = 4'h8;
    // Interrupt status bit positions.
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // Operation select of one divide request.
    typedef enum logic [1:0] {
        IDU_OP_DIVD  = 2'h0,
        IDU_OP_DIVDU = 2'h1,
        IDU_OP_DIVW  = 2'h2,
        IDU_OP_DIVWU = 2'h3
    } idu_op_type;

    // Controller states, Gray coded along idle, run, finish.
    typedef enum logic [1:0] {
        IDU_ST_IDLE = 2'b00,
        IDU_ST_RUN  = 2'b01,
        IDU_ST_DONE = 2'b11
    } idu_state_type;

endpackage : idu_pkg

// >>> hdl/idu_core.sv
// Unsigned restoring divider stepped one quotient bit per cycle.
module idu_core
    import idu_pkg::*;
(
    // Clocking.
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    // Start strobe with magnitudes.
    input  wire logic              start,
    input  wire logic [DATA_W-1:0] dividend_mag,
    input  wire logic [DATA_W-1:0] divisor_mag,
    // Result.
    output logic                   busy,
    output logic [DATA_W-1:0]      quot_mag
);

    logic [DATA_W-1:0] rem_r, rem_nxt;     // Partial remainder.
    logic [DATA_W-1:0] quo_r, quo_nxt;     // Dividend shifting into quotient.
    logic [DATA_W-1:0] dsr_r, dsr_nxt;     // Held divisor.
    logic [6:0]        cnt_r, cnt_nxt;     // Step counter.
    logic              busy_r, busy_nxt;   // Iteration in progress.

    ////////////////////////////////////////////////////////////////////////
    // Next-state: shift, trial subtract, keep if non-negative.
    always_comb begin
        logic [DATA_W:0] trial;
        trial = '0;
        rem_nxt = rem_r;
        quo_nxt = quo_r;
        dsr_nxt = dsr_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        if (start) begin
            rem_nxt = '0;
            quo_nxt = dividend_mag;
            dsr_nxt = divisor_mag;
            cnt_nxt = '0;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            // A 65-bit trial avoids losing the carry out of the shift.
            trial = {rem_r, quo_r[DATA_W-1]} - {1'b0, dsr_r};
            if (!trial[DATA_W]) begin
                rem_nxt = trial[DATA_W-1:0];
                quo_nxt = {quo_r[DATA_W-2:0], 1'b1};
            end else begin
                rem_nxt = {rem_r[DATA_W-2:0], quo_r[DATA_W-1]};
                quo_nxt = {quo_r[DATA_W-2:0], 1'b0};
            end
            cnt_nxt = cnt_r + 7'h01;
            busy_nxt = (cnt_r != STEP_LAST);
        end
    end

    // Registers, frozen while the clock enable is low.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rem_r <= '0;
            quo_r <= '0;
            dsr_r <= '0;
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else if (clk_en) begin
            rem_r <= rem_nxt;
            quo_r <= quo_nxt;
            dsr_r <= dsr_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign busy = busy_r;
    assign quot_mag = quo_r;

endmodule : idu_core

// >>> bench/idu_chk.sv
// Checker of the divide unit request timing and flag relations.
module idu_chk
    import idu_pkg::*;
(
    // Clocking.
    input wire logic              clk,
    input wire logic              sys_rst,
    // Request and result.
    input wire logic              req_valid,
    input wire logic              req_ready,
    input wire logic              res_valid,
    input wire logic [DATA_W-1:0] res_data,
    // Architectural flags.
    input wire logic              overflow_flag,
    input wire logic              summary_overflow,
    input wire logic [3:0]        condition_field_zero
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    // A request is taken when valid meets ready.
    sequence s_taken;
        req_valid && req_ready;
    endsequence
    // The answer is one result cycle, never stretched.
    sequence s_answer;
        res_valid ##1 !res_valid;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Fixed answer latency.
    a_answer_latency: assert property (s_taken |-> ##67 s_answer)
        else $error("result not delivered 67 cycles after request");
    a_busy_refuses: assert property (s_taken |=> !req_ready [*8])
        else $error("request accepted while a divide runs");
    a_idle_on_result: assert property (res_valid |-> req_ready)
        else $error("unit not idle when the result appears");
    // Flags move only with a result.
    a_flags_hold: assert property (!res_valid |->
        $stable({overflow_flag, summary_overflow, condition_field_zero}))
        else $error("flags changed without a result");
    a_so_sticky: assert property (summary_overflow |=> summary_overflow)
        else $error("summary overflow cleared");
    // Overflow is always folded into summary.
    a_ov_feeds_so: assert property (overflow_flag |-> summary_overflow)
        else $error("overflow set without summary overflow");
    a_cf_so_copy: assert property (res_valid && $changed(condition_field_zero)
        |-> condition_field_zero[CF_SO_POS] == summary_overflow)
        else $error("condition field summary bit differs from summary overflow");
    // Error result takes the fill value.
    a_err_fill: assert property (res_valid && $rose(overflow_flag)
        |-> res_data == UNDEF_FILL)
        else $error("error result is not the fill value");
endmodule : idu_chk

bind idu_top idu_chk u_chk (.*);

// >>> bench/idu_pipe_model.sv
// Pipeline model that issues divide requests and collects results.
module idu_pipe_model
    import idu_pkg::*;
(
    // Clocking.
    input  wire logic              clk,
    // Request towards the unit.
    output logic                   req_valid,
    input  wire logic              req_ready,
    output logic [1:0]             req_op,
    output logic [DATA_W-1:0]      first_source_reg,
    output logic [DATA_W-1:0]      second_source_reg,
    output logic                   ovf_enable,
    output logic                   record_condition_field,
    output logic                   mode_64,
    // Result from the unit.
    input  wire logic              res_valid,
    input  wire logic [DATA_W-1:0] res_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle request lines at time zero.
    initial begin
        {req_valid, req_op, ovf_enable, record_condition_field, mode_64} = '0;
        first_source_reg = '0;
        second_source_reg = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Holds the request until ready is seen, then waits for the pulse.
    // Called right after a rising edge; returns right after one too.
    task automatic issue(input logic [1:0] op, input logic [63:0] a, input logic [63:0] b,
                         input logic oe, input logic rc, input logic m64,
                         output logic [63:0] res);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req_op <= op;
        first_source_reg <= a;
        second_source_reg <= b;
        {ovf_enable, record_condition_field, mode_64} <= {oe, rc, m64};
        // Ready is stable mid-cycle, so the taking edge is the next one.
        do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 200);
        @(posedge clk);
        // Released operands no longer carry the old values.
        req_valid <= 1'b0;
        first_source_reg <= ~a;
        second_source_reg <= ~b;
        n = 0;
        // The result stands one cycle only, so it is looked at within it.
        do begin @(negedge clk); n++; end while (res_valid !== 1'b1 && n < 200);
        res = res_data;
        @(posedge clk);
    endtask : issue
endmodule : idu_pipe_model

// >>> bench/integer_divide_unit_tb.sv
// Self-checking bench of the integer divide unit.
module integer_divide_unit_tb;
    import idu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // One divide vector of the table.
    typedef struct packed {
        logic [1:0]  op;
        logic [63:0] a;
        logic [63:0] b;
        logic        oe;
        logic        rc;
        logic        m64;
    } idu_vec_type;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        req_valid, req_ready, ovf_enable, record_condition_field, mode_64;
    logic [1:0]  req_op;
    logic [63:0] first_source_reg, second_source_reg, res_data, res;
    logic        overflow_flag, summary_overflow, res_valid, irq, avs_waitrequest;
    logic [3:0]  condition_field_zero, avs_address = '0;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = '0, avs_readdata, rd;
    int          fail_count = 0, comparisons = 0, cycles = 0;
    // Expected architectural flags, kept across operations.
    logic        e_ov = 1'b0, e_so = 1'b0;
    logic [3:0]  e_cf = 4'h0;
    idu_vec_type vecs[12] = '{
        '{2'h0, 64'hffff_ffff_ffff_fff9, 64'h2, 1'b1, 1'b1, 1'b0},
        '{2'h0, 64'h8000_0000_0000_0000, 64'hffff_ffff_ffff_ffff, 1'b1, 1'b1, 1'b0},
        '{2'h1, 64'hffff_ffff_ffff_fff9, 64'h3, 1'b1, 1'b0, 1'b0},
        '{2'h1, 64'h5, 64'h0, 1'b0, 1'b1, 1'b0},
        '{2'h2, 64'h1234_5678_ffff_ff9c, 64'hdead_0000_0000_0007, 1'b1, 1'b1, 1'b0},
        '{2'h2, 64'h0000_0000_8000_0000, 64'h0000_0000_ffff_ffff, 1'b1, 1'b1, 1'b0},
        '{2'h3, 64'hffff_0000_ffff_fff0, 64'h1, 1'b1, 1'b1, 1'b0},
        '{2'h2, 64'h64, 64'h5, 1'b1, 1'b1, 1'b1},
        '{2'h0, 64'h9, 64'h0, 1'b1, 1'b1, 1'b0},
        '{2'h1, 64'h2, 64'h3, 1'b0, 1'b1, 1'b0},
        '{2'h3, 64'h64, 64'h5, 1'b0, 1'b1, 1'b0},
        '{2'h0, 64'h64, 64'hffff_ffff_ffff_fffb, 1'b1, 1'b0, 1'b0}};

    ////////////////////////////////////////////////////////////////////////
    // Clock at 200 MHz and a cycle ceiling against hangs.
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            complete_run();
        end
    end
    // The clock enable is held high; freezing is not exercised.
    idu_top u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .first_source_reg(first_source_reg),
        .second_source_reg(second_source_reg), .ovf_enable(ovf_enable),
        .record_condition_field(record_condition_field), .mode_64(mode_64),
        .overflow_flag(overflow_flag), .summary_overflow(summary_overflow),
        .condition_field_zero(condition_field_zero), .res_valid(res_valid),
        .res_data(res_data), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));
    idu_pipe_model u_pipe (.clk(clk), .req_valid(req_valid), .req_ready(req_ready),
        .req_op(req_op), .first_source_reg(first_source_reg),
        .second_source_reg(second_source_reg), .ovf_enable(ovf_enable),
        .record_condition_field(record_condition_field), .mode_64(mode_64),
        .res_valid(res_valid), .res_data(res_data));

    ////////////////////////////////////////////////////////////////////////
    // Compares one value and counts it.
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Bus write, held until waitrequest is seen low at an edge; one idle edge
    // follows so that its effect has settled and strobes never retoggle at once.
    task automatic bus_write(input logic [3:0] adr, input logic [31:0] dat);
        avs_write <= 1'b1;
        avs_address <= adr;
        avs_writedata <= dat;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus_write
    // Bus read, held until waitrequest is seen low; data are taken at that edge.
    task automatic bus_read(input logic [3:0] adr, output logic [31:0] dat);
        avs_read <= 1'b1;
        avs_address <= adr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        dat = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus_read
    // Runs one vector and checks result and flags against the model.
    task automatic run_vec(input idu_vec_type v);
        logic        err, wd;
        logic [63:0] q;
        logic [2:0]  c;
        wd = v.op[1];
        err = wd ? (v.b[31:0] == 32'h0) || (!v.op[0] && v.a[31:0] == MOST_NEG_WORD
                                            && v.b[31:0] == ALL_ONES[31:0])
                 : (v.b == 64'h0) || (!v.op[0] && v.a == MOST_NEG_DWORD && v.b == ALL_ONES);
        q = UNDEF_FILL;
        if (!err) begin
            case (v.op)
                2'h0: q = $signed(v.a) / $signed(v.b);
                2'h1: q = v.a / v.b;
                2'h2: q[31:0] = $signed(v.a[31:0]) / $signed(v.b[31:0]);
                default: q[31:0] = v.a[31:0] / v.b[31:0];
            endcase
        end
        c = wd ? {$signed(q[31:0]) < 0, $signed(q[31:0]) > 0, q[31:0] == 32'h0}
               : {$signed(q) < 0, $signed(q) > 0, q == 64'h0};
        if (err || (wd && v.m64)) c = UNDEF_CMP;
        if (v.oe) {e_ov, e_so} = {err, e_so | err};
        if (v.rc) e_cf = {c, e_so};
        u_pipe.issue(v.op, v.a, v.b, v.oe, v.rc, v.m64, res);
        check("quotient", q, res);
        check("overflow", 64'(e_ov), 64'(overflow_flag));
        check("summary", 64'(e_so), 64'(summary_overflow));
        check("condition", 64'(e_cf), 64'(condition_field_zero));
    endtask : run_vec
    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, registers, divide table, interrupts.
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        bus_read(OFS_IRQ_STATUS, rd);
        check("status reset", 64'h0, 64'(rd));
        bus_write(OFS_IRQ_MASK, 32'h1);
        foreach (vecs[i]) run_vec(vecs[i]);
        bus_read(OFS_UNIT_STATE, rd);
        check("state word", 64'(e_cf), 64'(rd));
        $display("Test divide table done");
        // Done bit with mask set raises the line; clearing drops it.
        check("irq raised", 64'h1, 64'(irq));
        bus_write(OFS_IRQ_STATUS, 32'h3);
        check("irq cleared", 64'h0, 64'(irq));
        bus_write(OFS_IRQ_MASK, 32'h0);
        run_vec(vecs[8]);
        bus_read(OFS_IRQ_STATUS, rd);
        check("status error", 64'h3, 64'(rd));
        check("irq masked", 64'h0, 64'(irq));
        bus_write(OFS_IRQ_MASK, 32'h2);
        check("irq error", 64'h1, 64'(irq));
        bus_write(4'hc, 32'hffff_ffff);
        bus_read(4'hc, rd);
        check("unmapped", 64'h0, 64'(rd));
        bus_read(OFS_IRQ_MASK, rd);
        check("mask kept", 64'h2, 64'(rd));
        $display("Test interrupt block done");
        complete_run();
    end
endmodule : integer_divide_unit_tb
